// [wiper_log_taper.sv]
// Functional notes
// - Commands 12 and 13 double wiper code
// - Commands 4 and 5 halve wiper code
// - Ganged steps update both channels together
// - Up is left shift, down right shift
// - Left shift of zero loads one
// - Left shift at midscale or above: full scale
// - Full scale stays full on left shift
// - Right shift truncates, sticks at zero
// - Bare chip-select strobe repeats last command
// - Sixteen words: wipers, thirteen user, tolerance
// - User words hold arbitrary sixteen-bit values
// - Stored codes restored: power-on, 1, 8, preset
// - Tolerance word cannot be written
// - Tolerance: sign, seven integer, eight fraction
// - Exactly one of 1024 taps on
// - Nibbles 1100,1101,0100,0101; address bit picks channel for 1100 and 0100
// - Command executes when chip select rises
// - Step commands ignore the data bytes
`timescale 1ns/10ps
module wiper_log_taper
   import wiper_log_pkg::*;
#(
   parameter logic TOL_SIGN = 1'b1,
   parameter logic [TOL_INT_W-1:0] TOL_INT = 7'h00,
   parameter logic [TOL_FRAC_W-1:0] TOL_FRAC = 8'h00
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic cs_n_pin,
   input wire logic sclk_pin,
   input wire logic sdi_pin,
   input wire logic preset_restore_strobe_n,
   output logic sdo_q,
   output logic sdo_oe_q,
   output logic [CHANNELS-1:0][WIPER_W-1:0] wiper_code_register_q,
   output logic [CHANNELS-1:0][TAPS-1:0] tap_switch_q
);

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   // Plus 6 dB step with end-point corrections
   function automatic logic [WIPER_W-1:0] step_up(
      input logic [WIPER_W-1:0] code
   );
      logic [WIPER_W-1:0] res;
      res = {code[WIPER_W-2:0], 1'b0};
      if (code == CODE_ZERO) begin
         res = CODE_ONE;
      end else if (code >= CODE_MIDSCALE) begin
         res = CODE_FULL;
      end
      return res;
   endfunction : step_up

   // Minus 6 dB step, LSB dropped, zero stays zero
   function automatic logic [WIPER_W-1:0] step_down(
      input logic [WIPER_W-1:0] code
   );
      return {1'b0, code[WIPER_W-1:1]};
   endfunction : step_down

   // One-hot tap select
   function automatic logic [TAPS-1:0] tap_decode(
      input logic [WIPER_W-1:0] code
   );
      logic [TAPS-1:0] onehot;
      onehot = '0;
      onehot[code] = 1'b1;
      return onehot;
   endfunction : tap_decode

   // Tolerance word in sign-magnitude form
   localparam logic [WORD_W-1:0] TOL_WORD = {TOL_SIGN, TOL_INT, TOL_FRAC};

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   logic [1:0] cs_sync_q;
   logic [1:0] sclk_sync_q;
   logic [1:0] sdi_sync_q;
   logic [1:0] pr_sync_q;
   logic [1:0] cs_sync_d;
   logic [1:0] sclk_sync_d;
   logic [1:0] sdi_sync_d;
   logic [1:0] pr_sync_d;

   // Two stages per pin
   always_comb begin
      cs_sync_d = {cs_sync_q[0], cs_n_pin};
      sclk_sync_d = {sclk_sync_q[0], sclk_pin};
      sdi_sync_d = {sdi_sync_q[0], sdi_pin};
      pr_sync_d = {pr_sync_q[0], preset_restore_strobe_n};
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cs_sync_q <= 2'h3;
         sclk_sync_q <= 2'h0;
         sdi_sync_q <= 2'h0;
         pr_sync_q <= 2'h3;
      end else begin
         cs_sync_q <= cs_sync_d;
         sclk_sync_q <= sclk_sync_d;
         sdi_sync_q <= sdi_sync_d;
         pr_sync_q <= pr_sync_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Frame engine, store and wipers

   frame_state_e state_q, state_d;
   logic cs_prev_q, cs_prev_d;
   logic sclk_prev_q, sclk_prev_d;
   logic pr_prev_q, pr_prev_d;
   logic [BIT_CNT_W-1:0] bit_cnt_q, bit_cnt_d;
   logic [FRAME_BITS-1:0] shreg_q, shreg_d;
   logic [FRAME_BITS-1:0] out_sr_q, out_sr_d;
   logic [FRAME_BITS-1:0] next_out_q, next_out_d;
   frame_s last_q, last_d;
   logic last_valid_q, last_valid_d;
   logic restore_pend_q, restore_pend_d;
   logic sdo_d;
   logic sdo_oe_d;
   logic [CHANNELS-1:0][WIPER_W-1:0] wiper_d;
   logic [WORD_W-1:0] store_q [STORE_DEPTH];
   logic [WORD_W-1:0] store_d [STORE_DEPTH];
   logic cs_fall;
   logic cs_rise;
   logic sclk_rise;
   logic sclk_fall;
   logic pr_fall;
   logic ch;

   // Next state of the whole command path
   always_comb begin
      state_d = state_q;
      cs_prev_d = cs_sync_q[1];
      sclk_prev_d = sclk_sync_q[1];
      pr_prev_d = pr_sync_q[1];
      bit_cnt_d = bit_cnt_q;
      shreg_d = shreg_q;
      out_sr_d = out_sr_q;
      next_out_d = next_out_q;
      last_d = last_q;
      last_valid_d = last_valid_q;
      restore_pend_d = 1'b0;
      sdo_d = sdo_q;
      sdo_oe_d = ~cs_sync_q[1];
      wiper_d = wiper_code_register_q;
      store_d = store_q;
      cs_fall = cs_prev_q & ~cs_sync_q[1];
      cs_rise = ~cs_prev_q & cs_sync_q[1];
      sclk_rise = ~sclk_prev_q & sclk_sync_q[1];
      sclk_fall = sclk_prev_q & ~sclk_sync_q[1];
      pr_fall = pr_prev_q & ~pr_sync_q[1];
      ch = last_q.addr[0];

      case (state_q)
         ST_IDLE: begin
            if (cs_fall) begin
               state_d = ST_FRAME;
               bit_cnt_d = '0;
               out_sr_d = next_out_q;
               sdo_d = next_out_q[FRAME_BITS-1];
            end
         end
         ST_FRAME: begin
            // Capture on rising, drive on falling serial clock
            if (sclk_rise) begin
               shreg_d = {shreg_q[FRAME_BITS-2:0], sdi_sync_q[1]};
               out_sr_d = {out_sr_q[FRAME_BITS-2:0], sdi_sync_q[1]};
               if (bit_cnt_q != FRAME_BITS_CNT) begin
                  bit_cnt_d = bit_cnt_q + 5'h01;
               end
            end
            if (sclk_fall) begin
               sdo_d = out_sr_q[FRAME_BITS-1];
            end
            if (cs_rise) begin
               state_d = ST_IDLE;
               if (bit_cnt_q == FRAME_BITS_CNT) begin
                  last_d = frame_s'(shreg_q);
                  last_valid_d = 1'b1;
                  next_out_d = shreg_q;
                  state_d = ST_EXEC;
               end else if (bit_cnt_q == '0 && last_valid_q) begin
                  state_d = ST_EXEC;
               end
            end
         end
         ST_EXEC: begin
            // Execute the held frame once
            state_d = ST_IDLE;
            case (last_q.cmd)
               CMD_RESTORE: begin
                  wiper_d[ch] = store_q[{3'h0, ch}][WIPER_W-1:0];
               end
               CMD_STORE_WIPER: begin
                  store_d[{3'h0, ch}] = {6'h00, wiper_code_register_q[ch]};
               end
               CMD_WRITE_STORE: begin
                  if (last_q.addr != ADDR_TOLERANCE) begin
                     store_d[last_q.addr] = last_q.data;
                  end
               end
               CMD_DB_DOWN: begin
                  wiper_d[ch] = step_down(wiper_code_register_q[ch]);
               end
               CMD_DB_DOWN_ALL: begin
                  for (int i = 0; i < CHANNELS; i++) begin
                     wiper_d[i] = step_down(wiper_code_register_q[i]);
                  end
               end
               CMD_REFRESH: begin
                  for (int i = 0; i < CHANNELS; i++) begin
                     wiper_d[i] = store_q[i][WIPER_W-1:0];
                  end
               end
               CMD_READ_STORE: begin
                  next_out_d = {last_q.cmd, last_q.addr,
                                store_q[last_q.addr]};
               end
               CMD_READ_WIPER: begin
                  next_out_d = {last_q.cmd, last_q.addr, 6'h00,
                                wiper_code_register_q[ch]};
               end
               CMD_WRITE_WIPER: begin
                  wiper_d[ch] = last_q.data[WIPER_W-1:0];
               end
               CMD_DB_UP: begin
                  wiper_d[ch] = step_up(wiper_code_register_q[ch]);
               end
               CMD_DB_UP_ALL: begin
                  for (int i = 0; i < CHANNELS; i++) begin
                     wiper_d[i] = step_up(wiper_code_register_q[i]);
                  end
               end
               default: begin
                  // No operation; step data bytes never read
               end
            endcase
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase

      // Power-on and preset strobe restore both wipers
      if (restore_pend_q || pr_fall) begin
         for (int i = 0; i < CHANNELS; i++) begin
            wiper_d[i] = store_q[i][WIPER_W-1:0];
         end
      end
      store_d[ADDR_TOLERANCE] = TOL_WORD;
   end

   // Register the command path
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state_q <= ST_IDLE;
         cs_prev_q <= 1'b1;
         sclk_prev_q <= 1'b0;
         pr_prev_q <= 1'b1;
         bit_cnt_q <= '0;
         shreg_q <= FRAME_RESET;
         out_sr_q <= FRAME_RESET;
         next_out_q <= FRAME_RESET;
         last_q <= frame_s'(FRAME_RESET);
         last_valid_q <= 1'b0;
         restore_pend_q <= 1'b1;
         sdo_q <= 1'b0;
         sdo_oe_q <= 1'b0;
         wiper_code_register_q <= {CHANNELS{WIPER_RESET}};
      end else begin
         state_q <= state_d;
         cs_prev_q <= cs_prev_d;
         sclk_prev_q <= sclk_prev_d;
         pr_prev_q <= pr_prev_d;
         bit_cnt_q <= bit_cnt_d;
         shreg_q <= shreg_d;
         out_sr_q <= out_sr_d;
         next_out_q <= next_out_d;
         last_q <= last_d;
         last_valid_q <= last_valid_d;
         restore_pend_q <= restore_pend_d;
         sdo_q <= sdo_d;
         sdo_oe_q <= sdo_oe_d;
         wiper_code_register_q <= wiper_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Nonvolatile store words

   for (genvar w = 0; w < STORE_DEPTH; w++) begin : g_store
      localparam logic [WORD_W-1:0] INIT =
         (w == int'(ADDR_TOLERANCE)) ? TOL_WORD :
         (w <= int'(ADDR_WIPER2)) ? STORE_WIPER_RESET : STORE_USER_RESET;

      // One word of the map
      always_ff @(posedge ref_clk) begin
         if (sys_rst) begin
            store_q[w] <= INIT;
         end else begin
            store_q[w] <= store_d[w];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Tap switch decoders

   for (genvar c = 0; c < CHANNELS; c++) begin : g_tap
      logic [TAPS-1:0] tap_d;

      // Decode the next wiper code
      always_comb begin
         tap_d = tap_decode(wiper_d[c]);
      end

      always_ff @(posedge ref_clk) begin
         if (sys_rst) begin
            tap_switch_q[c] <= tap_decode(WIPER_RESET);
         end else begin
            tap_switch_q[c] <= tap_d;
         end
      end
   end

endmodule : wiper_log_taper

// [wiper_log_pkg.sv]
package wiper_log_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Widths and wiper code limits
   localparam int WIPER_W = 10;
   localparam int TAPS = 1024;
   localparam int CHANNELS = 2;
   localparam int WORD_W = 16;
   localparam int STORE_DEPTH = 16;
   localparam int FRAME_BITS = 24;
   localparam int BIT_CNT_W = 5;
   localparam logic [BIT_CNT_W-1:0] FRAME_BITS_CNT = 5'h18;
   localparam logic [WIPER_W-1:0] CODE_ZERO = 10'h000;
   localparam logic [WIPER_W-1:0] CODE_ONE = 10'h001;
   localparam logic [WIPER_W-1:0] CODE_MIDSCALE = 10'h200;
   localparam logic [WIPER_W-1:0] CODE_FULL = 10'h3ff;

   ////////////////////////////////////////////////////////////////////////
   // Nonvolatile map addresses
   localparam logic [3:0] ADDR_WIPER1 = 4'h0;
   localparam logic [3:0] ADDR_WIPER2 = 4'h1;
   localparam logic [3:0] ADDR_USER_FIRST = 4'h2;
   localparam logic [3:0] ADDR_USER_SECOND = 4'h3;
   localparam logic [3:0] ADDR_USER_LAST = 4'he;
   localparam logic [3:0] ADDR_TOLERANCE = 4'hf;

   ////////////////////////////////////////////////////////////////////////
   // Tolerance word layout
   localparam int TOL_SIGN_BIT = 15;
   localparam int TOL_INT_LSB = 8;
   localparam int TOL_INT_W = 7;
   localparam int TOL_FRAC_W = 8;

   ////////////////////////////////////////////////////////////////////////
   // Values after reset
   localparam logic [WIPER_W-1:0] WIPER_RESET = 10'h200;
   localparam logic [WORD_W-1:0] STORE_WIPER_RESET = 16'h0200;
   localparam logic [WORD_W-1:0] STORE_USER_RESET = 16'h0000;
   localparam logic [FRAME_BITS-1:0] FRAME_RESET = 24'h000000;

   ////////////////////////////////////////////////////////////////////////
   // Command nibbles
   localparam logic [3:0] CMD_NOP = 4'h0;
   localparam logic [3:0] CMD_RESTORE = 4'h1;
   localparam logic [3:0] CMD_STORE_WIPER = 4'h2;
   localparam logic [3:0] CMD_WRITE_STORE = 4'h3;
   localparam logic [3:0] CMD_DB_DOWN = 4'h4;
   localparam logic [3:0] CMD_DB_DOWN_ALL = 4'h5;
   localparam logic [3:0] CMD_REFRESH = 4'h8;
   localparam logic [3:0] CMD_READ_STORE = 4'h9;
   localparam logic [3:0] CMD_READ_WIPER = 4'ha;
   localparam logic [3:0] CMD_WRITE_WIPER = 4'hb;
   localparam logic [3:0] CMD_DB_UP = 4'hc;
   localparam logic [3:0] CMD_DB_UP_ALL = 4'hd;

   ////////////////////////////////////////////////////////////////////////
   // Types
   typedef struct packed {
      logic [3:0] cmd;
      logic [3:0] addr;
      logic [15:0] data;
   } frame_s;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_FRAME = 3'b010,
      ST_EXEC = 3'b100
   } frame_state_e;

endpackage : wiper_log_pkg

// [wiper_log_props.sv]
`timescale 1ns/10ps
module wiper_log_props
   import wiper_log_pkg::*;
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic cs_n_pin,
   input wire logic sclk_pin,
   input wire logic sdi_pin,
   input wire logic preset_restore_strobe_n,
   input wire logic sdo_q,
   input wire logic sdo_oe_q,
   input wire logic [CHANNELS-1:0][WIPER_W-1:0] wiper_code_register_q,
   input wire logic [CHANNELS-1:0][TAPS-1:0] tap_switch_q
);
   logic [3:0] quiet_q;
   logic [3:0] quiet_d;
   logic cs_q;
   logic pre_q;

   // Cycles since chip-select release, preset fall or reset
   always_comb begin
      quiet_d = (quiet_q == 4'hf) ? quiet_q : quiet_q + 4'h1;
      if (sys_rst || (cs_n_pin && !cs_q)) begin
         quiet_d = 4'h0;
      end
      if (pre_q && !preset_restore_strobe_n) begin
         quiet_d = 4'h0;
      end
   end

   // Registers of the helper counter
   always_ff @(posedge ref_clk) begin
      quiet_q <= quiet_d;
      cs_q <= cs_n_pin;
      pre_q <= preset_restore_strobe_n;
   end

   ////////////////////////////////////////////////////////////////////////
   a_taps_one_hot: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      $onehot(tap_switch_q[0]) && $onehot(tap_switch_q[1]))
      else $error("tap select not one-hot");
   a_tap_first_code: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      tap_switch_q[0][wiper_code_register_q[0]])
      else $error("tap 1 off code");
   a_tap_second_code: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      tap_switch_q[1][wiper_code_register_q[1]])
      else $error("tap 2 off code");
   a_reset_mid_code: assert property (
      @(posedge ref_clk)
      sys_rst |=> wiper_code_register_q[0] == WIPER_RESET
         && wiper_code_register_q[1] == WIPER_RESET)
      else $error("wiper not midscale after reset");
   a_change_after_release: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      !$stable(wiper_code_register_q) |-> quiet_q <= 4'ha)
      else $error("wiper moved outside execute window");
   a_hold_in_frame: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (!cs_n_pin && preset_restore_strobe_n)[*8]
      |=> $stable(wiper_code_register_q))
      else $error("wiper moved during frame");
   a_oe_when_selected: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (!cs_n_pin)[*4] |-> sdo_oe_q)
      else $error("sdo not enabled");
   a_oe_off_idle: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (cs_n_pin)[*4] |-> !sdo_oe_q)
      else $error("sdo enabled while idle");

   c_full_scale: cover property (
      @(posedge ref_clk) wiper_code_register_q[0] == CODE_FULL);
   c_zero_scale: cover property (
      @(posedge ref_clk) wiper_code_register_q[1] == CODE_ZERO);
   c_preset: cover property (
      @(posedge ref_clk) $fell(preset_restore_strobe_n));
   c_ganged: cover property (@(posedge ref_clk)
      $changed(wiper_code_register_q[0])
      && $changed(wiper_code_register_q[1]));
endmodule : wiper_log_props

bind wiper_log_taper wiper_log_props i_wiper_log_props (.ref_clk(ref_clk),
   .sys_rst(sys_rst), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin),
   .sdi_pin(sdi_pin), .preset_restore_strobe_n(preset_restore_strobe_n),
   .sdo_q(sdo_q), .sdo_oe_q(sdo_oe_q),
   .wiper_code_register_q(wiper_code_register_q), .tap_switch_q(tap_switch_q));

// [spi_host.sv]
`timescale 1ns/10ps
module spi_host (
   input wire logic ref_clk,
   input wire logic sdo_q,
   output logic cs_n_pin,
   output logic sclk_pin,
   output logic sdi_pin
);
   // Idle bus: deselected, clock low
   initial begin
      cs_n_pin = 1'b1;
      sclk_pin = 1'b0;
      sdi_pin = 1'b0;
   end

   // Whole 24-bit frame MSB first, reply sampled on sclk rise
   task automatic xfer(input logic [23:0] w, output logic [23:0] r);
      @(negedge ref_clk);
      cs_n_pin = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         sdi_pin = w[i];
         #40 sclk_pin = 1'b1;
         r = {r[22:0], sdo_q};
         #40 sclk_pin = 1'b0;
      end
      #40 cs_n_pin = 1'b1;
      sdi_pin = ~sdi_pin; // No stale level once released
      #100;
   endtask : xfer

   // Bare chip-select strobe, no clocks
   task automatic strobe();
      @(negedge ref_clk);
      cs_n_pin = 1'b0;
      #60 cs_n_pin = 1'b1;
      #100;
   endtask : strobe
endmodule : spi_host

// [testbench.sv]
`timescale 1ns/10ps
module testbench;
   import wiper_log_pkg::*;
   logic ref_clk, sys_rst, preset_n, cs_n, sclk, sdi, sdo, oe;
   logic [CHANNELS-1:0][WIPER_W-1:0] wip;
   logic [CHANNELS-1:0][TAPS-1:0] taps;
   logic [23:0] rd;
   logic [9:0] e;
   logic [15:0] exp_word;
   int num_errors = 0;
   int checks_done = 0;
   int cyc = 0;

   wiper_log_taper #(.TOL_SIGN(1'b1), .TOL_INT(7'h1c), .TOL_FRAC(8'h0f))
      i_wiper_log_taper (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .cs_n_pin(cs_n), .sclk_pin(sclk), .sdi_pin(sdi),
      .preset_restore_strobe_n(preset_n), .sdo_q(sdo), .sdo_oe_q(oe),
      .wiper_code_register_q(wip), .tap_switch_q(taps));
   spi_host i_spi_host (.ref_clk(ref_clk), .sdo_q(sdo), .cs_n_pin(cs_n),
      .sclk_pin(sclk), .sdi_pin(sdi));

   ////////////////////////////////////////////////////////////////////////
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // Hang guard
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 40000) begin
         num_errors++;
         final_report();
      end
   end

   task final_report;
      $display("checks %0d, errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : final_report

   task chk(input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: expected %h, got %h", $time, exp, got);
      end
   endtask : chk

   // Both wiper codes at once, with their tap selects
   task cw(input logic [9:0] e0, input logic [9:0] e1);
      chk({6'h00, e0}, {6'h00, wip[0]});
      chk({6'h00, e1}, {6'h00, wip[1]});
      chk(16'h0002, 16'($countones(taps)));
      chk(16'h0003, {14'h0000, taps[1][e1], taps[0][e0]});
   endtask : cw

   task fr(input logic [23:0] w);
      i_spi_host.xfer(w, rd);
   endtask : fr

   // Expected doubling step with end corrections
   function automatic logic [9:0] up(input logic [9:0] x);
      if (x == 10'h000) return 10'h001;
      if (x >= 10'h200) return 10'h3ff;
      return {x[8:0], 1'b0};
   endfunction : up

   ////////////////////////////////////////////////////////////////////////
   initial begin
      sys_rst = 1'b1;
      preset_n = 1'b1;
      repeat (12) @(negedge ref_clk);
      sys_rst = 1'b0;
      repeat (4) @(negedge ref_clk);
      cw(10'h200, 10'h200);
      // Left-shift walk from zero on channel 1
      fr(24'hb00000);
      fr(24'hc0ffff);
      e = 10'h001;
      cw(e, 10'h200);
      for (int i = 0; i < 11; i++) begin
         i_spi_host.strobe();
         e = up(e);
         cw(e, 10'h200);
      end
      // Right-shift walk to zero on channel 2
      fr(24'hb103ff);
      fr(24'h410000);
      e = 10'h1ff;
      cw(10'h3ff, e);
      for (int i = 0; i < 10; i++) begin
         i_spi_host.strobe();
         e = e >> 1;
         cw(10'h3ff, e);
      end
      // Ganged steps
      fr(24'hb00155);
      fr(24'hb10003);
      fr(24'hd0ffff);
      cw(10'h2aa, 10'h006);
      fr(24'h5f0000);
      cw(10'h155, 10'h003);
      i_spi_host.strobe();
      cw(10'h0aa, 10'h001);
      // Wiper store and read-back paths
      fr(24'h200000);
      fr(24'h900000);
      fr(24'ha10000);
      chk(16'h00aa, rd[15:0]);
      fr(24'h000000);
      chk(16'h0001, rd[15:0]);
      // User words and read-only tolerance
      for (int a = 2; a < 16; a++) fr({4'h3, a[3:0], 16'ha5c0 ^ a[15:0]});
      fr(24'h920000);
      for (int a = 3; a < 17; a++) begin
         fr({4'h9, a[3:0], 16'h0000});
         exp_word = (a < 16) ? 16'ha5c0 ^ (a[15:0] - 16'h1) : 16'h9c0f;
         chk(exp_word, rd[15:0]);
      end
      // Restore paths
      fr(24'h300123);
      fr(24'h310321);
      fr(24'hb00000);
      fr(24'hb10000);
      fr(24'h100000);
      cw(10'h123, 10'h000);
      fr(24'h800000);
      cw(10'h123, 10'h321);
      fr(24'hb00000);
      fr(24'hb10000);
      preset_n = 1'b0;
      repeat (4) @(negedge ref_clk);
      preset_n = 1'b1;
      repeat (10) @(negedge ref_clk);
      cw(10'h123, 10'h321);
      final_report();
   end
endmodule : testbench
